//--- acquisition_trigger_control.sv
// Acquisition trigger controller: source select, slope qualify, holdoff,
// normal/auto/peak-to-peak modes. Probe and external inputs are async pins.
// Host requests and power samples come from logic on clk_sys_i.
`default_nettype none

module acquisition_trigger_control
   import trig_ctrl_pkg::*;
#(
   parameter int AUTO_SHORT = AUTO_SHORT_US,
   parameter int AUTO_LONG = AUTO_LONG_US
)
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire trig_cfg_t cfg_i,
   input wire host_req_t req_i,
   input wire power_sample_t sample_i,
   input wire logic first_probe_threshold_source_i,
   input wire logic second_probe_threshold_source_i,
   input wire logic external_threshold_i,
   output trig_status_t status_o
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] prev;
      logic [5:0] tick_cnt;
      logic [19:0] holdoff_cnt;
      logic [19:0] auto_cnt;
      logic bus_arm;
      trig_mode_t mode;
      logic [LEVEL_W-1:0] level;
      logic [LEVEL_W-1:0] pmax;
      logic [LEVEL_W-1:0] pmin;
      logic sweep_sync;
      logic meas_start;
      logic auto_trace;
   } state_t;

   localparam logic [5:0] TICK_LAST = 6'(US_CYCLES - 1);

   state_t st;
   state_t next_st;
   logic tick;
   logic armed;
   logic edge_seen;
   logic signal_src;
   logic bus_armed_src;
   logic accept;
   logic auto_fire;
   logic [19:0] holdoff_load;
   logic [19:0] auto_limit;
   logic [2:0] rise;
   logic [2:0] fall;
   logic [2:0] sel_edge;
   logic [LEVEL_W:0] mid_sum;

   // Which probe or external line a source refers to
   function automatic logic [1:0] line_of(input trig_source_t s);
      unique case (s)
         SRC_SECOND_PROBE, SRC_BUS_SECOND_PROBE: line_of = 2'h1;
         SRC_EXTERNAL, SRC_BUS_EXTERNAL: line_of = 2'h2;
         default: line_of = 2'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decode and qualify
   always_comb
   begin
      tick = (st.tick_cnt == TICK_LAST);
      armed = (st.holdoff_cnt == 20'h00000);
      rise = st.sync2 & ~st.prev;
      fall = ~st.sync2 & st.prev;
      sel_edge = cfg_i.slope_neg ? fall : rise;
      edge_seen = sel_edge[line_of(cfg_i.source)];
      bus_armed_src = (cfg_i.source == SRC_BUS_FIRST_PROBE)
                   || (cfg_i.source == SRC_BUS_SECOND_PROBE)
                   || (cfg_i.source == SRC_BUS_EXTERNAL);
      signal_src = (cfg_i.source != SRC_IMMEDIATE) && (cfg_i.source != SRC_BUS);
      // Out-of-range holdoff settings are clamped into the legal span
      if (cfg_i.holdoff_us == HOLDOFF_OFF_US)
      begin
         holdoff_load = HOLDOFF_OFF_US;
      end
      else if (cfg_i.holdoff_us < HOLDOFF_MIN_US)
      begin
         holdoff_load = HOLDOFF_MIN_US;
      end
      else if (cfg_i.holdoff_us > HOLDOFF_MAX_US)
      begin
         holdoff_load = HOLDOFF_MAX_US;
      end
      else
      begin
         holdoff_load = cfg_i.holdoff_us;
      end
      auto_limit = cfg_i.long_span ? 20'(AUTO_LONG) : 20'(AUTO_SHORT);
      // Accept only while armed; the immediate source bypasses holdoff
      accept = 1'b0;
      unique case (cfg_i.source)
         SRC_IMMEDIATE: accept = req_i.launch;
         SRC_BUS: accept = armed && req_i.bus_trig;
         default:
            accept = armed && edge_seen && (cfg_i.meas_mode == MEAS_PULSE)
                  && (!bus_armed_src || st.bus_arm);
      endcase
      // Auto timeout only makes sense for signal sources in pulse mode
      auto_fire = (st.mode != TMODE_NORMAL) && signal_src
               && (cfg_i.meas_mode == MEAS_PULSE) && tick
               && (st.auto_cnt >= auto_limit - 20'h00001);
      mid_sum = {1'b0, st.pmax} + {1'b0, st.pmin};
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.sync1 = {external_threshold_i, second_probe_threshold_source_i,
                       first_probe_threshold_source_i};
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      next_st.tick_cnt = tick ? 6'h00 : st.tick_cnt + 6'h01;

      // Holdoff down-counter
      if (accept && cfg_i.source != SRC_IMMEDIATE)
      begin
         next_st.holdoff_cnt = holdoff_load;
      end
      else if (tick && !armed)
      begin
         next_st.holdoff_cnt = st.holdoff_cnt - 20'h00001;
      end

      // Bus arm: a new bus trigger wins over the clear by a firing edge
      if (bus_armed_src && req_i.bus_trig)
      begin
         next_st.bus_arm = 1'b1;
      end
      else if (accept || !bus_armed_src)
      begin
         next_st.bus_arm = 1'b0;
      end

      // Time since the last trigger, in microseconds
      if (accept || auto_fire)
      begin
         next_st.auto_cnt = 20'h00000;
      end
      else if (tick && st.auto_cnt != 20'hFFFFF)
      begin
         next_st.auto_cnt = st.auto_cnt + 20'h00001;
      end

      // Results
      next_st.meas_start = accept;
      next_st.sweep_sync = (accept || auto_fire) && (cfg_i.meas_mode == MEAS_PULSE);
      next_st.auto_trace = auto_fire;

      // Mode and level writes; a level write leaves peak mode
      if (req_i.level_wr)
      begin
         next_st.level = req_i.level;
         if (st.mode == TMODE_PEAK)
         begin
            next_st.mode = TMODE_AUTO;
         end
      end
      else if (req_i.mode_wr)
      begin
         next_st.mode = req_i.mode;
      end
      else if (st.mode == TMODE_PEAK && st.pmax >= st.pmin)
      begin
         next_st.level = mid_sum[LEVEL_W:1];
      end

      // Peak tracking restarts at each auto trigger and on a mode write to peak, so a changing signal is followed
      if (auto_fire || (req_i.mode_wr && req_i.mode == TMODE_PEAK))
      begin
         next_st.pmax = '0;
         next_st.pmin = '1;
      end
      else if (sample_i.valid)
      begin
         if (sample_i.power > st.pmax)
         begin
            next_st.pmax = sample_i.power;
         end
         if (sample_i.power < st.pmin)
         begin
            next_st.pmin = sample_i.power;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         st <= '0;
         st.mode <= TMODE_RESET;
         st.pmin <= '1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs
   always_comb
   begin
      status_o.sweep_sync = st.sweep_sync;
      status_o.meas_start = st.meas_start;
      status_o.auto_trace = st.auto_trace;
      status_o.armed = armed;
      status_o.holdoff_busy = !armed;
      status_o.bus_armed = st.bus_arm;
      status_o.mode = st.mode;
      status_o.level = st.level;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_holdoff_blocks: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (st.holdoff_cnt != 20'h00000 && cfg_i.source != SRC_IMMEDIATE) |=> !st.meas_start)
      else $error("trigger accepted during holdoff");

   a_holdoff_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (accept && cfg_i.source != SRC_IMMEDIATE) |=> st.holdoff_cnt == $past(holdoff_load))
      else $error("holdoff not loaded on trigger");

   a_holdoff_range: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (accept && cfg_i.source != SRC_IMMEDIATE && cfg_i.holdoff_us != HOLDOFF_OFF_US)
      |=> (st.holdoff_cnt >= HOLDOFF_MIN_US) && (st.holdoff_cnt <= HOLDOFF_MAX_US))
      else $error("holdoff count out of range");

   a_tick_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (!armed && !accept) |=> (st.holdoff_cnt == $past(st.holdoff_cnt)
      || st.holdoff_cnt == $past(st.holdoff_cnt) - 20'h00001))
      else $error("holdoff step wrong");

   a_rearm_time: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (st.holdoff_cnt == 20'h00001 && tick && !accept) |=> armed)
      else $error("no re-arm at holdoff end");

   a_immediate_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (cfg_i.source == SRC_IMMEDIATE && req_i.launch) |=> st.meas_start)
      else $error("immediate launch did not start");

   a_bus_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (cfg_i.source == SRC_BUS && !req_i.bus_trig) |=> !st.meas_start)
      else $error("bus source fired without bus trigger");

   a_bus_arm_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (bus_armed_src && req_i.bus_trig) |=> st.bus_arm)
      else $error("bus trigger did not arm");

   a_pulse_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (signal_src && cfg_i.meas_mode != MEAS_PULSE) |=> !st.meas_start && !st.sweep_sync)
      else $error("signal source fired outside pulse mode");

   a_sync_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      st.sweep_sync |-> $past(cfg_i.meas_mode) == MEAS_PULSE)
      else $error("trace sync outside pulse mode");

   a_level_to_auto: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (req_i.level_wr && st.mode == TMODE_PEAK) |=> st.mode == TMODE_AUTO)
      else $error("level write left peak mode set");

   a_normal_no_auto: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      st.mode == TMODE_NORMAL |=> !st.auto_trace)
      else $error("auto trace in normal mode");

endmodule

`default_nettype wire

//--- acquisition_trigger_control_bench.sv
// Self-checking bench for the acquisition trigger controller.
// Assumes the auto timeouts are shortened to 20 us and 50 us by parameter.
`default_nettype none

module acquisition_trigger_control_bench
   import trig_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic reset = 1'b1;
   trig_cfg_t cfg = '0;
   host_req_t req = '0;
   power_sample_t sample = '0;
   logic first, second, ext;
   trig_status_t status;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;

   acquisition_trigger_control #(.AUTO_SHORT(20), .AUTO_LONG(50)) u_acquisition_trigger_control (
      .clk_sys_i(clk), .reset_i(reset), .cfg_i(cfg), .req_i(req), .sample_i(sample),
      .first_probe_threshold_source_i(first), .second_probe_threshold_source_i(second),
      .external_threshold_i(ext), .status_o(status));

   threshold_lines u_threshold_lines (.clk_i(clk), .first_o(first), .second_o(second),
      .ext_o(ext));

   // 40 MHz clock and a free cycle count for measuring spans
   initial
      forever #12.5 clk = ~clk;
   always @(posedge clk)
      cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic set_cfg(input trig_source_t s, input meas_mode_t m, input logic neg,
      input logic lng, input logic [19:0] h);
      @(posedge clk);
      cfg <= '{source: s, meas_mode: m, slope_neg: neg, long_span: lng, holdoff_us: h};
   endtask

   // One-cycle host pulse: 0 launch, 1 bus trigger, 2 mode write, 3 level write
   task automatic send(input int kind, input logic [15:0] val);
      host_req_t r;
      r = '0;
      r.launch = (kind == 0);
      r.bus_trig = (kind == 1);
      r.mode_wr = (kind == 2);
      r.mode = trig_mode_t'(val[2:0]);
      r.level_wr = (kind == 3);
      r.level = val;
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= '0;
      #1;
   endtask

   // Cycles until meas_start (sel 0) or auto_trace (sel 1); lim if never
   task automatic wait_bit(input int sel, input int lim, output int n);
      n = 0;
      while (n < lim)
      begin
         #1;
         if (((sel == 0) ? status.meas_start : status.auto_trace) === 1'b1)
            break;
         @(posedge clk);
         n++;
      end
   endtask

   // Moves a comparator line and judges whether a measurement starts
   task automatic toggle(input int sel, input logic v, input logic fires);
      int n;
      u_threshold_lines.set_line(sel, v);
      wait_bit(0, 8, n);
      check(n < 8, fires);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_sources;
      check(status.armed, 1'b1);
      check(status.bus_armed, 1'b0);
      check(status.mode, TMODE_PEAK);
      check(status.level, 16'h0000);
      set_cfg(SRC_IMMEDIATE, MEAS_PULSE, 1'b0, 1'b0, 20'h0000A);
      send(0, 16'h0000);
      check(status.meas_start, 1'b1);
      set_cfg(SRC_BUS, MEAS_MODULATED, 1'b0, 1'b0, 20'h00000);
      toggle(0, 1'b1, 1'b0);
      toggle(0, 1'b0, 1'b0);
      send(1, 16'h0000);
      check(status.meas_start, 1'b1);
      check(status.sweep_sync, 1'b0);
      set_cfg(SRC_BUS, MEAS_PULSE, 1'b0, 1'b0, 20'h00000);
      send(1, 16'h0000);
      check(status.sweep_sync, 1'b1);
      set_cfg(SRC_BUS_SECOND_PROBE, MEAS_PULSE, 1'b0, 1'b0, 20'h00000);
      toggle(1, 1'b1, 1'b0);
      toggle(1, 1'b0, 1'b0);
      send(1, 16'h0000);
      check(status.meas_start, 1'b0);
      check(status.bus_armed, 1'b1);
      toggle(1, 1'b1, 1'b1);
      // The firing edge uses up the arm
      check(status.bus_armed, 1'b0);
      toggle(1, 1'b0, 1'b0);
      $display("test sources done");
   endtask

   task automatic t_slope;
      set_cfg(SRC_FIRST_PROBE, MEAS_PULSE, 1'b1, 1'b0, 20'h00000);
      toggle(0, 1'b1, 1'b0);
      toggle(0, 1'b0, 1'b1);
      set_cfg(SRC_FIRST_PROBE, MEAS_PULSE, 1'b0, 1'b0, 20'h00000);
      toggle(1, 1'b1, 1'b0);
      toggle(1, 1'b0, 1'b0);
      toggle(0, 1'b1, 1'b1);
      toggle(0, 1'b0, 1'b0);
      set_cfg(SRC_EXTERNAL, MEAS_PULSE, 1'b0, 1'b0, 20'h00000);
      toggle(2, 1'b1, 1'b1);
      toggle(2, 1'b0, 1'b0);
      set_cfg(SRC_FIRST_PROBE, MEAS_CW, 1'b0, 1'b0, 20'h00000);
      toggle(0, 1'b1, 1'b0);
      toggle(0, 1'b0, 1'b0);
      $display("test slope done");
   endtask

   // A setting of 1 us must behave as the 10 us floor
   task automatic t_holdoff;
      int c0;
      set_cfg(SRC_FIRST_PROBE, MEAS_PULSE, 1'b0, 1'b0, 20'h00001);
      toggle(0, 1'b1, 1'b1);
      c0 = cyc;
      check(status.holdoff_busy, 1'b1);
      toggle(0, 1'b0, 1'b0);
      toggle(0, 1'b1, 1'b0);
      toggle(0, 1'b0, 1'b0);
      while (status.holdoff_busy === 1'b1 && cyc - c0 < 500)
         @(posedge clk) #1;
      check((cyc - c0 >= 355) && (cyc - c0 <= 405), 1'b1);
      toggle(0, 1'b1, 1'b1);
      toggle(0, 1'b0, 1'b0);
      set_cfg(SRC_FIRST_PROBE, MEAS_PULSE, 1'b0, 1'b0, 20'h00000);
      while (status.holdoff_busy === 1'b1 && cyc - c0 < 1000)
         @(posedge clk) #1;
      toggle(0, 1'b1, 1'b1);
      check(status.holdoff_busy, 1'b0);
      toggle(0, 1'b0, 1'b0);
      toggle(0, 1'b1, 1'b1);
      toggle(0, 1'b0, 1'b0);
      $display("test holdoff done");
   endtask

   task automatic t_auto;
      int n;
      send(2, 16'h0001);
      check(status.mode, TMODE_NORMAL);
      wait_bit(1, 1000, n);
      check(n, 1000);
      send(2, 16'h0002);
      wait_bit(1, 900, n);
      check(n < 900, 1'b1);
      check(status.sweep_sync, 1'b1);
      @(posedge clk);
      wait_bit(1, 900, n);
      check((n >= 759) && (n <= 839), 1'b1);
      set_cfg(SRC_FIRST_PROBE, MEAS_PULSE, 1'b0, 1'b1, 20'h00000);
      wait_bit(1, 2100, n);
      check(n < 2100, 1'b1);
      @(posedge clk);
      wait_bit(1, 2100, n);
      check((n >= 1959) && (n <= 2039), 1'b1);
      $display("test auto done");
   endtask

   task automatic t_peak;
      send(2, 16'h0004);
      // Samples change only on a rising edge, like every other input
      @(posedge clk);
      sample <= '{valid: 1'b1, power: 16'h0100};
      @(posedge clk);
      sample <= '{valid: 1'b1, power: 16'h0300};
      @(posedge clk);
      sample <= '0;
      repeat (3) @(posedge clk);
      #1 check(status.level, 16'h0200);
      send(3, 16'h1234);
      check(status.mode, TMODE_AUTO);
      check(status.level, 16'h1234);
      $display("test peak done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence after an 8-cycle reset
   initial
   begin
      cfg.source <= SOURCE_RESET;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk) #1;
      t_sources();
      t_slope();
      t_holdoff();
      t_auto();
      t_peak();
      wrap_up();
   end

   // Tests need about 7000 cycles; cut a hang short well after that
   initial
   begin
      repeat (25000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end
endmodule

`default_nettype wire

//--- threshold_lines.sv
// Far-side model: comparator outputs of both probes and the external input.
// Assumes the bench calls set_line from its own process, one line at a time.
`default_nettype none

module threshold_lines
(
   input wire logic clk_i,
   output logic first_o,
   output logic second_o,
   output logic ext_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] line = 3'h0;

   // Levels move only just after a rising edge; the block resynchronises them
   task automatic set_line(input int sel, input logic v);
      @(posedge clk_i);
      line[sel] <= v;
   endtask

   // Comparators are plain levels, never released
   assign first_o = line[0];
   assign second_o = line[1];
   assign ext_o = line[2];
endmodule

`default_nettype wire

//--- trig_ctrl_pkg.sv
// Package for the acquisition trigger controller: enumerations, carrier
// structs and timing constants shared by the design and its bench.
// Assumes a single 40 MHz system clock.
`default_nettype none

package trig_ctrl_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 25;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;

   // Holdoff limits in microseconds; zero means holdoff is off
   localparam logic [19:0] HOLDOFF_OFF_US = 20'h00000;
   localparam logic [19:0] HOLDOFF_MIN_US = 20'h0000A;
   localparam logic [19:0] HOLDOFF_MAX_US = 20'hF423F;

   // Auto trigger timeouts, printed in milliseconds
   localparam int AUTO_SHORT_MS = 100;
   localparam int AUTO_LONG_MS = 500;
   localparam int AUTO_SHORT_US = AUTO_SHORT_MS * 1000;
   localparam int AUTO_LONG_US = AUTO_LONG_MS * 1000;

   localparam int LEVEL_W = 16;

   typedef enum logic [2:0] {
      SRC_IMMEDIATE = 3'h0,
      SRC_BUS = 3'h1,
      SRC_FIRST_PROBE = 3'h2,
      SRC_SECOND_PROBE = 3'h3,
      SRC_EXTERNAL = 3'h4,
      SRC_BUS_FIRST_PROBE = 3'h5,
      SRC_BUS_SECOND_PROBE = 3'h6,
      SRC_BUS_EXTERNAL = 3'h7
   } trig_source_t;

   typedef enum logic [1:0] {
      MEAS_PULSE = 2'h0,
      MEAS_MODULATED = 2'h1,
      MEAS_CW = 2'h2,
      MEAS_STATISTICAL = 2'h3
   } meas_mode_t;

   typedef enum logic [2:0] {
      TMODE_NORMAL = 3'h1,
      TMODE_AUTO = 3'h2,
      TMODE_PEAK = 3'h4
   } trig_mode_t;

   localparam trig_source_t SOURCE_RESET = SRC_FIRST_PROBE;
   localparam trig_mode_t TMODE_RESET = TMODE_PEAK;
   localparam logic SLOPE_RESET = 1'b0;

   // Static configuration from the host side
   typedef struct packed {
      trig_source_t source;
      meas_mode_t meas_mode;
      logic slope_neg;
      logic long_span;
      logic [19:0] holdoff_us;
   } trig_cfg_t;

   // Host bus events and writes, one-cycle pulses
   typedef struct packed {
      logic launch;
      logic bus_trig;
      logic mode_wr;
      trig_mode_t mode;
      logic level_wr;
      logic [LEVEL_W-1:0] level;
   } host_req_t;

   // Detected power samples for level tracking
   typedef struct packed {
      logic valid;
      logic [LEVEL_W-1:0] power;
   } power_sample_t;

   // Trigger results
   typedef struct packed {
      logic sweep_sync;
      logic meas_start;
      logic auto_trace;
      logic armed;
      logic holdoff_busy;
      logic bus_armed;
      trig_mode_t mode;
      logic [LEVEL_W-1:0] level;
   } trig_status_t;

endpackage

`default_nettype wire
